// ### rdnf_buf.sv
// rdnf_buf: two-entry buffer of transition records with valid/ready both sides
// assumes active-low reset from the parent, released in step with clk
`timescale 1ns/100ps
`default_nettype none
module rdnf_buf
  import rdnf_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstSyncN,
  // fill side
  input  wire logic          inValid,
  output logic               inReady,
  input  wire rdnf_edge_type inData,
  // drain side
  output logic               outValid,
  input  wire logic          outReady,
  output rdnf_edge_type      outData
);
  rdnf_edge_type mem_q [BUF_DEPTH];
  rdnf_edge_type mem_d [BUF_DEPTH];
  logic          wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [1:0]    cnt_q, cnt_d;
  logic          push, pop;

  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    mem_d     = mem_q;
    wrPtr_d   = wrPtr_q;
    rdPtr_d   = rdPtr_q;
    cnt_d     = cnt_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d        = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d   = ~rdPtr_q;
    end
    cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      mem_q[0]  <= '0;
      mem_q[1]  <= '0;
      wrPtr_q   <= 1'b0;
      rdPtr_q   <= 1'b0;
      cnt_q     <= 2'h0;
    end else begin
      mem_q     <= mem_d;
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      cnt_q     <= cnt_d;
    end
  end
endmodule : rdnf_buf
`default_nettype wire

// ### rdnf_filter.sv
// rdnf_filter: clocked digital noise filter and retriggerable read pulse
// assumes write-enable input synchronous to clk; comparator input passes a two-flop synchronizer here
`timescale 1ns/100ps
`default_nettype none
module rdnf_filter
  import rdnf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // drive side
  input  wire logic compIn,
  input  wire logic writeEnable,
  input  wire logic readGateEn,
  // host side
  output logic      writeBusy,
  output logic      readDataPulseOut,
  // observation
  output logic      delayOneShotN
);
  // ==========================================================================
  // reset release
  logic rstMeta_q, rstSyncN;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN  <= rstMeta_q;
    end
  end

  // ==========================================================================
  // input synchronizer and write busy
  logic compMeta_q, compSync_q, compDly_q, writeBusy_q;
  logic compSync_d, compDly_d, writeBusy_d;
  always_comb begin
    compSync_d  = compMeta_q;
    compDly_d   = compSync_q;
    writeBusy_d = writeEnable;
  end
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      compMeta_q  <= RST_LEVEL;
      compSync_q  <= RST_LEVEL;
      compDly_q   <= RST_LEVEL;
      writeBusy_q <= 1'b0;
    end else begin
      compMeta_q  <= compIn;
      compSync_q  <= compSync_d;
      compDly_q   <= compDly_d;
      writeBusy_q <= writeBusy_d;
    end
  end
  assign writeBusy = writeBusy_q;

  // input edge detector: xor of level and its delayed copy
  logic inEdge;
  assign inEdge = compSync_q ^ compDly_q;

  // ==========================================================================
  // delay one-shot and noise filter flip-flop
  rdnf_dly_state_type dState_q, dState_d;
  logic [CNT_W-1:0]   dCnt_q, dCnt_d;
  logic               filt_q, filt_d, dRise;
  always_comb begin
    dState_d = dState_q;
    dCnt_d   = dCnt_q;
    dRise    = 1'b0;
    case (dState_q)
      ST_IDLE: begin
        if (inEdge && !writeBusy_q) begin
          dState_d = ST_DELAY;
          dCnt_d   = rdnf_cyc(DELAY_CYC - 1);
        end
      end
      ST_DELAY: begin
        if (writeBusy_q) begin
          dState_d = ST_IDLE;
        end else if (dCnt_q == '0) begin
          dState_d = ST_IDLE;
          dRise    = 1'b1;
        end else begin
          dCnt_d = CNT_W'(dCnt_q - 1'b1);
        end
      end
      default: dState_d = ST_IDLE;
    endcase
    // sample present level; a glitch already gone leaves it unchanged
    filt_d = dRise ? compSync_q : filt_q;
  end
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      dState_q <= ST_IDLE;
      dCnt_q   <= '0;
      filt_q   <= RST_LEVEL;
    end else begin
      dState_q <= dState_d;
      dCnt_q   <= dCnt_d;
      filt_q   <= filt_d;
    end
  end
  assign delayOneShotN = (dState_q != ST_DELAY);

  // ==========================================================================
  // output edge detector feeding the buffer
  logic filtDly_q;
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) filtDly_q <= RST_LEVEL;
    else           filtDly_q <= filt_q;
  end
  logic          outEdge, bufInReady, bufOutValid, bufOutReady;
  rdnf_edge_type bufIn;
  assign outEdge     = filt_q ^ filtDly_q;
  assign bufIn.level = filt_q;

  // buffer drains one edge per cycle; its ready is tied high, so no edge ever waits for the pulser
  rdnf_buf u_buf (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .inValid  (outEdge),
    .inReady  (bufInReady),
    .inData   (bufIn),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  ()
  );

  // ==========================================================================
  // retriggerable output one-shot
  logic [CNT_W-1:0] pCnt_q, pCnt_d;
  logic             pulse_q, pulse_d, gateOut_q, gateOut_d;
  assign bufOutReady = 1'b1;
  always_comb begin
    pCnt_d  = pCnt_q;
    pulse_d = pulse_q;
    if (writeBusy_q) begin
      pCnt_d  = '0;
      pulse_d = 1'b0;
    end else if (bufOutValid) begin
      pCnt_d  = rdnf_cyc(PULSE_CYC - 1);
      pulse_d = 1'b1;
    end else if (pulse_q) begin
      if (pCnt_q == '0) pulse_d = 1'b0;
      else pCnt_d = CNT_W'(pCnt_q - 1'b1);
    end
    gateOut_d = pulse_d && readGateEn;
  end
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pCnt_q    <= '0;
      pulse_q   <= 1'b0;
      gateOut_q <= 1'b0;
    end else begin
      pCnt_q    <= pCnt_d;
      pulse_q   <= pulse_d;
      gateOut_q <= gateOut_d;
    end
  end
  assign readDataPulseOut = gateOut_q;

  // ==========================================================================
  // assertions
  localparam int PW = PULSE_CYC;
  sequence s_edge_seen;
    !writeBusy_q && inEdge && dState_q == ST_IDLE;
  endsequence
  property p_in_edge;
    @(posedge clk) disable iff (!rstSyncN)
      $changed(compSync_q) |-> inEdge;
  endproperty
  a_in_edge: assert property (p_in_edge) else $error("edge missed");
  property p_delay_start;
    @(posedge clk) disable iff (!rstSyncN)
      s_edge_seen |=> !delayOneShotN;
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("delay not started");
  // delay length witness: cycles spent in the delay state so far
  logic [CNT_W-1:0] dLow_q, dLow_d;
  always_comb begin
    dLow_d = (dState_q == ST_DELAY) ? CNT_W'(dLow_q + 1'b1) : '0;
  end
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) dLow_q <= '0;
    else           dLow_q <= dLow_d;
  end
  sequence s_delay_done;
    dRise;
  endsequence
  property p_delay_len;
    @(posedge clk) disable iff (!rstSyncN)
      s_delay_done |-> dLow_q == rdnf_cyc(DELAY_CYC - 1);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay wrong length");
  property p_delay_max;
    @(posedge clk) disable iff (!rstSyncN)
      (dState_q == ST_DELAY) |-> dLow_q < rdnf_cyc(DELAY_CYC);
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("delay too long");
  property p_wb_delay;
    @(posedge clk) disable iff (!rstSyncN)
      writeBusy_q |=> delayOneShotN;
  endproperty
  a_wb_delay: assert property (p_wb_delay) else $error("delay during write");
  property p_sample;
    @(posedge clk) disable iff (!rstSyncN)
      dRise |=> filt_q == $past(compSync_q);
  endproperty
  a_sample: assert property (p_sample) else $error("filter sample wrong");
  property p_hold;
    @(posedge clk) disable iff (!rstSyncN)
      !dRise |=> $stable(filt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("filter changed without edge");
  property p_out_edge;
    @(posedge clk) disable iff (!rstSyncN)
      $changed(filt_q) |-> outEdge;
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("output edge missed");
  property p_buf_room;
    @(posedge clk) disable iff (!rstSyncN)
      outEdge |-> bufInReady;
  endproperty
  a_buf_room: assert property (p_buf_room) else $error("edge buffer overflow");
  property p_retrig;
    @(posedge clk) disable iff (!rstSyncN)
      (bufOutValid && !writeBusy_q) |=> pulse_q && pCnt_q == rdnf_cyc(PW - 1);
  endproperty
  a_retrig: assert property (p_retrig) else $error("pulse not restarted");
  property p_width;
    @(posedge clk) disable iff (!rstSyncN)
      (pulse_q && pCnt_q == '0 && !bufOutValid && !writeBusy_q) |=> !pulse_q;
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_wb_pulse;
    @(posedge clk) disable iff (!rstSyncN)
      writeBusy_q |=> !pulse_q && !readDataPulseOut;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("pulse during write");
  property p_gate;
    @(posedge clk) disable iff (!rstSyncN)
      readDataPulseOut |-> $past(readGateEn);
  endproperty
  a_gate: assert property (p_gate) else $error("ungated read pulse");
  property p_wbusy;
    @(posedge clk) disable iff (!rstSyncN)
      writeEnable |=> writeBusy;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("write busy not set");
endmodule : rdnf_filter
`default_nettype wire

// ### rdnf_filter_tb_top.sv
// rdnf_filter_tb_top: self-checking bench for the read data noise filter and pulser
// assumes the package cycle counts and a 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
module rdnf_filter_tb_top
  import rdnf_pkg::*;
;
  typedef struct packed {int len; logic we; logic gate; int pulses; int width;} rdnf_row_type;
  logic        clk;
  logic        resetn;
  logic        compIn;
  logic        writeEnable;
  logic        readGateEn;
  logic        writeBusy;
  logic        readDataPulseOut;
  logic        delayOneShotN;
  logic        clearStats;
  logic [15:0] pulseCount;
  logic [15:0] lastWidth;
  logic [15:0] dlyRun;
  logic [15:0] dlyLast;
  int          n_errors;
  int          total_checks;
  // width 0 means only the tolerance band is checked, and nothing when pulses is 0
  rdnf_row_type rows [5] = '{'{60, 0, 1, 2, 0}, '{DELAY_CYC - 1, 0, 1, 0, 0},
                              '{20, 0, 1, 1, PULSE_CYC + 20}, '{60, 1, 1, 0, 0},
                              '{60, 0, 0, 0, 0}};
  // ==========================================================================
  // design and host
  rdnf_filter rdnf_filter_i (.clk(clk), .resetn(resetn), .compIn(compIn),
    .writeEnable(writeEnable), .readGateEn(readGateEn), .writeBusy(writeBusy),
    .readDataPulseOut(readDataPulseOut), .delayOneShotN(delayOneShotN));
  rdnf_host_model rdnf_host_model_i (.clk(clk), .readDataPulseOut(readDataPulseOut),
    .clearStats(clearStats), .pulseCount(pulseCount), .lastWidth(lastWidth));
  // ==========================================================================
  // delay one-shot low-run monitor
  always_ff @(posedge clk) begin
    if (clearStats) begin
      dlyRun  <= 16'h0000;
      dlyLast <= 16'h0000;
    end else if (!delayOneShotN) begin
      dlyRun <= dlyRun + 16'h0001;
    end else if (dlyRun != 16'h0000) begin
      dlyLast <= dlyRun;
      dlyRun  <= 16'h0000;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic run_row(input rdnf_row_type r);
    writeEnable = r.we;
    readGateEn  = r.gate;
    clearStats  = 1'b1;
    tick(2);
    clearStats = 1'b0;
    check(32'(writeBusy), 32'(r.we));
    compIn = 1'b1;
    tick(r.len);
    compIn = 1'b0;
    tick(100);
    check(32'(pulseCount), 32'(r.pulses));
    check(32'(dlyLast), r.we ? 32'h0 : 32'(DELAY_CYC));
    if (r.width != 0) begin
      check(32'(lastWidth), 32'(r.width));
    end else if (r.pulses != 0) begin
      check(32'(lastWidth >= PULSE_MIN_CYC && lastWidth <= PULSE_MAX_CYC), 32'h1);
    end
    writeEnable = 1'b0;
    readGateEn  = 1'b1;
    tick(10);
  endtask : run_row
  // ==========================================================================
  // main sequence
  initial begin
    n_errors     = 0;
    total_checks = 0;
    resetn       = 1'b0;
    compIn       = 1'b0;
    writeEnable  = 1'b0;
    readGateEn   = 1'b1;
    clearStats   = 1'b1;
    tick(6);
    check({29'h0, writeBusy, readDataPulseOut, delayOneShotN}, 32'h1);
    resetn = 1'b1;
    tick(5);
    for (int i = 0; i < 5; i++) begin
      run_row(rows[i]);
    end
    // reset in the middle of an active pulse
    compIn = 1'b1;
    tick(25);
    resetn = 1'b0;
    tick(1);
    check({29'h0, writeBusy, readDataPulseOut, delayOneShotN}, 32'h1);
    compIn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(5);
    run_row(rows[0]);
    wrap_up();
  end
  // ==========================================================================
  // watchdog, a few times the expected run length
  initial begin
    #(CLK_PERIOD_NS * 5000);
    n_errors++;
    wrap_up();
  end
endmodule : rdnf_filter_tb_top
`default_nettype wire

// ### rdnf_host_model.sv
// rdnf_host_model: host side that counts read data pulses and measures their width
// assumes pulses are registered on the rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module rdnf_host_model (
  // clock
  input  wire logic        clk,
  // read data from the drive
  input  wire logic        readDataPulseOut,
  // statistics
  input  wire logic        clearStats,
  output logic      [15:0] pulseCount,
  output logic      [15:0] lastWidth
);
  logic [15:0] runCnt;
  logic        prevLevel;
  // ==========================================================================
  // pulse statistics
  always_ff @(posedge clk) begin
    if (clearStats) begin
      pulseCount <= 16'h0000;
      lastWidth  <= 16'h0000;
      runCnt     <= 16'h0000;
      prevLevel  <= 1'b0;
    end else begin
      prevLevel <= readDataPulseOut;
      if (readDataPulseOut) begin
        runCnt <= runCnt + 16'h0001;
      end
      if (readDataPulseOut && !prevLevel) begin
        pulseCount <= pulseCount + 16'h0001;
      end
      if (!readDataPulseOut && prevLevel) begin
        lastWidth <= runCnt;
        runCnt    <= 16'h0000;
      end
    end
  end
endmodule : rdnf_host_model
`default_nettype wire

// ### rdnf_pkg.sv
// rdnf_pkg: constants and carrier types for the read data noise filter and pulser
// assumes a single 50 MHz clock; all times converted to whole cycles here
package rdnf_pkg;
  // ==========================================================================
  // clock
  localparam int CLK_PERIOD_NS = 20;
  // ==========================================================================
  // times in ns, as printed or chosen
  localparam int PULSE_NOM_NS    = 700;  // output pulse nominal width
  localparam int PULSE_TOL_NS    = 400;  // allowed deviation either way
  localparam int FILT_DELAY_NS   = 200;  // noise rejection delay interval
  localparam int EDGE_PULSE_NS   = 20;   // edge detector pulse width
  // ==========================================================================
  // cycle counts; nominal width rounds down (longest-type figure)
  localparam int PULSE_CYC  = PULSE_NOM_NS / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC = (PULSE_NOM_NS - PULSE_TOL_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC = (PULSE_NOM_NS + PULSE_TOL_NS) / CLK_PERIOD_NS;
  localparam int DELAY_CYC  = (FILT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EDGE_CYC   = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 8;
  // ==========================================================================
  // reset values and buffer depth
  localparam logic RST_LEVEL = 1'b0;
  localparam int   BUF_DEPTH = 2;
  // ==========================================================================
  // carrier: one filtered transition passed through the buffer
  typedef struct packed {
    logic level;   // filtered level after the transition
  } rdnf_edge_type;
  typedef enum logic [0:0] {ST_IDLE, ST_DELAY} rdnf_dly_state_type;

  function automatic logic [CNT_W-1:0] rdnf_cyc(input int n);
    rdnf_cyc = CNT_W'(n);
  endfunction : rdnf_cyc
endpackage : rdnf_pkg
